// ==== hw/lcs_defs.vh ====
`ifndef LCS_DEFS_VH
`define LCS_DEFS_VH

// ------------------------------------------------------------
// Serial control port addressing
// ------------------------------------------------------------
`define LCS_SLAVE_ADDR      7'h70
`define LCS_OFS_CTRL        8'h08
`define LCS_OFS_STATUS      8'h09
`define LCS_OFS_MON_CFG     8'h10
`define LCS_OFS_EVENT       8'h11

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define LCS_RST_CTRL        8'h34
`define LCS_RST_MON_CFG     8'h00

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define LCS_CTRL_PWR_BIT    0
`define LCS_CTRL_EDGE_BIT   1
`define LCS_STAT_HP_BIT     0
`define LCS_STAT_RSEN_BIT   2
`define LCS_EVT_HP_BIT      0
`define LCS_EVT_RSEN_BIT    1
`define LCS_MCFG_MODE_LSB   0
`define LCS_MCFG_MODE_MSB   1

// ------------------------------------------------------------
// Monitor sense modes
// ------------------------------------------------------------
`define LCS_MODE_HOTPLUG    2'h0
`define LCS_MODE_RSEN       2'h1
`define LCS_MODE_EVENT      2'h2

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define LCS_CLK_PERIOD_NS   5
`define LCS_T_RESET_NS      100
`define LCS_T_RESET_CYC     ((`LCS_T_RESET_NS + `LCS_CLK_PERIOD_NS - 1) / `LCS_CLK_PERIOD_NS)

// ------------------------------------------------------------
// Synchroniser input bit positions and width
// ------------------------------------------------------------
`define LCS_SY_SCL          0
`define LCS_SY_SDA          1
`define LCS_SY_SEL          2
`define LCS_SY_HP           3
`define LCS_SY_RSEN         4
`define LCS_SY_EDGE         5
`define LCS_SY_PDN          6
`define LCS_SY_W            7

`endif

// ==== hw/lcs_sync.v ====
`timescale 1ns/100ps

module lcs_sync #(
    parameter W = 1
) (
    input  wire         i_clk,
    input  wire         i_rst_b,
    input  wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);

    // ------------------------------------------------------------
    // Two-stage synchroniser, one chain per bit
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            reg meta_q;
            reg sync_q;
            always @(posedge i_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= i_async[g];
                    sync_q <= meta_q;
                end
            end
            assign o_sync[g] = sync_q;
        end
    endgenerate

endmodule

// ==== hw/lcs_top.v ====
`timescale 1ns/100ps
`include "lcs_defs.vh"

// Notes on behaviour
// - A low select level enables the two-wire slave port and takes configuration through it.
// - A high select level disables the port and takes configuration from straps and defaults.
// - The select level asynchronously resets the serial port controller without any clock.
// - A high-to-low select change after the minimum high time resets the serial port logic.
// - With the port disabled, monitor sense is high when a powered receiver is sensed.
// - With the port enabled, monitor sense shows hot plug, receiver sense or a change event.
// - Monitor sense is open drain and is only ever pulled low.
// - The bus clock line is an input only and is never driven.
// - The bus data line is received and driven only low for data and acknowledge.
// - While powered down all link data and clock drivers are placed in high impedance.
// - The slave answers only its seven-bit address, bit 0 selects read, no burst access.
// - Port state runs from bus clock line edges and needs no video clock, also in power down.
// - With the port enabled, edge and power-down straps are ignored for register bits.
module lcs_top (
    input  wire       i_clk,
    input  wire       i_rst_b,
    input  wire       i_iface_select_reset,
    input  wire       i_scl_in,
    input  wire       i_sda_in,
    input  wire       i_hot_plug,
    input  wire       i_rx_sense,
    input  wire       i_edge_strap,
    input  wire       i_power_down_n,
    output reg        o_scl_out,
    output reg        o_scl_oe,
    output reg        o_sda_out,
    output reg        o_sda_oe,
    output reg        o_monitor_sense_out,
    output reg        o_monitor_sense_oe,
    output reg        o_edge_rising,
    output reg        o_power_down_n,
    output reg  [2:0] o_link_data_en,
    output reg        o_link_clock_en
);

    // ------------------------------------------------------------
    // State codes
    // ------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'h0;
    localparam [3:0] ST_ADDR = 4'h1;
    localparam [3:0] ST_AACK = 4'h2;
    localparam [3:0] ST_SUB  = 4'h3;
    localparam [3:0] ST_SACK = 4'h4;
    localparam [3:0] ST_WDAT = 4'h5;
    localparam [3:0] ST_WACK = 4'h6;
    localparam [3:0] ST_RDAT = 4'h7;
    localparam [3:0] ST_RACK = 4'h8;

    localparam integer T_RESET_INT = `LCS_T_RESET_CYC;
    localparam [7:0]   T_RESET_CYC = T_RESET_INT[7:0];

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    wire [`LCS_SY_W-1:0] sy;

    lcs_sync #(
        .W (`LCS_SY_W)
    ) u_sync (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_async ({i_power_down_n, i_edge_strap, i_rx_sense, i_hot_plug,
                   i_iface_select_reset, i_sda_in, i_scl_in}),
        .o_sync  (sy)
    );

    wire scl_s  = sy[`LCS_SY_SCL];
    wire sda_s  = sy[`LCS_SY_SDA];
    wire sel_s  = sy[`LCS_SY_SEL];
    wire hp_s   = sy[`LCS_SY_HP];
    wire rsen_s = sy[`LCS_SY_RSEN];
    wire edge_s = sy[`LCS_SY_EDGE];
    wire pdn_s  = sy[`LCS_SY_PDN];

    // Pin level acts straight on the port controller, no clock needed
    wire port_rst_b = i_rst_b & ~i_iface_select_reset;

    // ------------------------------------------------------------
    // Select high-time qualification
    // ------------------------------------------------------------
    reg  [7:0] sel_cnt_q;
    reg        sel_long_q;
    reg        sel_d1_q;
    reg        port_clr_q;

    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sel_cnt_q  <= 8'h00;
            sel_long_q <= 1'b0;
            sel_d1_q   <= 1'b0;
            port_clr_q <= 1'b0;
        end else begin
            sel_d1_q <= sel_s;
            if (!sel_s) begin
                sel_cnt_q  <= 8'h00;
                sel_long_q <= 1'b0;
            end else if (sel_cnt_q < T_RESET_CYC) begin
                sel_cnt_q <= sel_cnt_q + 8'h01;
            end else begin
                sel_long_q <= 1'b1;
            end
            // Falling select after a qualified high time clears the port
            port_clr_q <= sel_d1_q & ~sel_s & sel_long_q;
        end
    end

    // ------------------------------------------------------------
    // Bus line edge and condition detection
    // ------------------------------------------------------------
    reg  scl_d_q;
    reg  sda_d_q;

    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            scl_d_q <= 1'b1;
            sda_d_q <= 1'b1;
        end else begin
            scl_d_q <= scl_s;
            sda_d_q <= sda_s;
        end
    end

    // Oversampled bus clock edges drive the slave, no video clock involved
    wire scl_rise = scl_s & ~scl_d_q;
    wire scl_fall = ~scl_s & scl_d_q;
    wire start_c  = scl_s & scl_d_q & sda_d_q & ~sda_s;
    wire stop_c   = scl_s & scl_d_q & ~sda_d_q & sda_s;
    wire port_en  = ~sel_s;

    // ------------------------------------------------------------
    // Register read decode
    // ------------------------------------------------------------
    reg [7:0] ctrl_q;
    reg [7:0] mcfg_q;
    reg [1:0] evt_q;

    function [7:0] rd_mux;
        input [7:0] ofs;
        input [7:0] ctrl;
        input [7:0] mcfg;
        input [1:0] evt;
        input       hp;
        input       rsen;
        begin
            rd_mux = 8'h00;
            case (ofs)
                `LCS_OFS_CTRL:     rd_mux = ctrl;
                `LCS_OFS_MON_CFG:  rd_mux = mcfg;
                `LCS_OFS_EVENT:    rd_mux = {6'h00, evt};
                `LCS_OFS_STATUS: begin
                    rd_mux[`LCS_STAT_HP_BIT]   = hp;
                    rd_mux[`LCS_STAT_RSEN_BIT] = rsen;
                end
                default:           rd_mux = 8'h00;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // Slave state machine
    // ------------------------------------------------------------
    reg  [3:0] st_q;
    reg  [3:0] cnt_q;
    reg  [7:0] sr_q;
    reg  [7:0] ptr_q;
    reg        rw_q;
    reg        ack_q;
    reg        ackon_q;
    reg        wrote_q;
    reg        drv_q;
    reg        wr_stb_q;
    reg  [7:0] wr_dat_q;

    wire [7:0] byte_in = {sr_q[6:0], sda_s};
    wire [2:0] rd_idx  = 3'h7 - cnt_q[2:0];
    wire [7:0] rd_val  = rd_mux(ptr_q, ctrl_q, mcfg_q, evt_q, hp_s, rsen_s);

    always @(posedge i_clk or negedge port_rst_b) begin
        if (!port_rst_b) begin
            st_q     <= ST_IDLE;
            cnt_q    <= 4'h0;
            sr_q     <= 8'h00;
            ptr_q    <= 8'h00;
            rw_q     <= 1'b0;
            ack_q    <= 1'b0;
            ackon_q  <= 1'b0;
            wrote_q  <= 1'b0;
            drv_q    <= 1'b0;
            wr_stb_q <= 1'b0;
            wr_dat_q <= 8'h00;
        end else begin
            wr_stb_q <= 1'b0;
            if (port_clr_q || !port_en) begin
                st_q  <= ST_IDLE;
                drv_q <= 1'b0;
            end else if (start_c) begin
                st_q    <= ST_ADDR;
                cnt_q   <= 4'h0;
                ackon_q <= 1'b0;
                drv_q   <= 1'b0;
            end else if (stop_c) begin
                st_q  <= ST_IDLE;
                drv_q <= 1'b0;
            end else if (scl_rise) begin
                case (st_q)
                    ST_ADDR, ST_SUB, ST_WDAT: begin
                        sr_q  <= byte_in;
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == 4'h7) begin
                            cnt_q <= 4'h0;
                            ack_q <= 1'b1;
                            if (st_q == ST_ADDR) begin
                                // Only our address is answered
                                if (byte_in[7:1] == `LCS_SLAVE_ADDR) begin
                                    st_q    <= ST_AACK;
                                    rw_q    <= byte_in[0];
                                    wrote_q <= 1'b0;
                                end else begin
                                    st_q <= ST_IDLE;
                                end
                            end else if (st_q == ST_SUB) begin
                                st_q  <= ST_SACK;
                                ptr_q <= byte_in;
                            end else begin
                                st_q <= ST_WACK;
                                // A second data byte is refused: no burst
                                ack_q    <= ~wrote_q;
                                wr_stb_q <= ~wrote_q;
                                wr_dat_q <= byte_in;
                                wrote_q  <= 1'b1;
                            end
                        end
                    end
                    ST_RDAT: cnt_q <= cnt_q + 4'h1;
                    ST_RACK: st_q  <= ST_IDLE;
                    default: ;
                endcase
            end else if (scl_fall) begin
                case (st_q)
                    ST_AACK, ST_SACK, ST_WACK: begin
                        if (!ackon_q) begin
                            drv_q   <= ack_q;
                            ackon_q <= 1'b1;
                        end else begin
                            ackon_q <= 1'b0;
                            drv_q   <= 1'b0;
                            if (st_q == ST_AACK && rw_q) begin
                                st_q  <= ST_RDAT;
                                cnt_q <= 4'h0;
                                sr_q  <= rd_val;
                                drv_q <= ~rd_val[7];
                            end else if (st_q == ST_AACK) begin
                                st_q <= ST_SUB;
                            end else begin
                                st_q <= ST_WDAT;
                            end
                        end
                    end
                    ST_RDAT: begin
                        if (cnt_q == 4'h8) begin
                            st_q  <= ST_RACK;
                            drv_q <= 1'b0;
                        end else begin
                            // A one bit is left to the pull-up
                            drv_q <= ~sr_q[rd_idx];
                        end
                    end
                    default: drv_q <= 1'b0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Port registers and change events
    // ------------------------------------------------------------
    reg hp_d_q;
    reg rsen_d_q;

    wire [1:0] evt_set = {rsen_s ^ rsen_d_q, hp_s ^ hp_d_q};
    wire       evt_wr  = wr_stb_q && ptr_q == `LCS_OFS_EVENT;

    always @(posedge i_clk or negedge port_rst_b) begin
        if (!port_rst_b) begin
            ctrl_q   <= `LCS_RST_CTRL;
            mcfg_q   <= `LCS_RST_MON_CFG;
            evt_q    <= 2'h0;
            hp_d_q   <= 1'b0;
            rsen_d_q <= 1'b0;
        end else if (port_clr_q) begin
            ctrl_q <= `LCS_RST_CTRL;
            mcfg_q <= `LCS_RST_MON_CFG;
            evt_q  <= 2'h0;
        end else begin
            hp_d_q   <= hp_s;
            rsen_d_q <= rsen_s;
            if (wr_stb_q && ptr_q == `LCS_OFS_CTRL) begin
                ctrl_q <= wr_dat_q;
            end
            if (wr_stb_q && ptr_q == `LCS_OFS_MON_CFG) begin
                mcfg_q <= wr_dat_q;
            end
            // Write one to clear; a change in the same cycle still sets
            evt_q <= (evt_q & ~(evt_wr ? wr_dat_q[1:0] : 2'h0)) | evt_set;
        end
    end

    // ------------------------------------------------------------
    // Configuration and pin outputs
    // ------------------------------------------------------------
    wire [1:0] mode  = mcfg_q[`LCS_MCFG_MODE_MSB:`LCS_MCFG_MODE_LSB];
    reg        mon_hi;
    reg        pdn_eff;
    reg        edge_eff;

    always @* begin
        // Synchronised select keeps mode switching glitch free
        if (port_en) begin
            pdn_eff  = ctrl_q[`LCS_CTRL_PWR_BIT];
            edge_eff = ctrl_q[`LCS_CTRL_EDGE_BIT];
            case (mode)
                `LCS_MODE_HOTPLUG: mon_hi = hp_s;
                `LCS_MODE_RSEN:    mon_hi = rsen_s;
                `LCS_MODE_EVENT:   mon_hi = ~|evt_q;
                default:           mon_hi = hp_s;
            endcase
        end else begin
            pdn_eff  = pdn_s;
            edge_eff = edge_s;
            mon_hi   = rsen_s;
        end
    end

    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_scl_out           <= 1'b0;
            o_scl_oe            <= 1'b0;
            o_sda_out           <= 1'b0;
            o_sda_oe            <= 1'b0;
            o_monitor_sense_out <= 1'b0;
            o_monitor_sense_oe  <= 1'b0;
            o_edge_rising       <= 1'b0;
            o_power_down_n      <= 1'b0;
            o_link_data_en      <= 3'h0;
            o_link_clock_en     <= 1'b0;
        end else begin
            // No clock stretching, so the clock line is never driven
            o_scl_out           <= 1'b0;
            o_scl_oe            <= 1'b0;
            o_sda_out           <= 1'b0;
            o_sda_oe            <= drv_q & port_en;
            o_monitor_sense_out <= 1'b0;
            o_monitor_sense_oe  <= ~mon_hi;
            o_edge_rising       <= edge_eff;
            o_power_down_n      <= pdn_eff;
            o_link_data_en      <= {3{pdn_eff}};
            o_link_clock_en     <= pdn_eff;
        end
    end

endmodule

// ==== verif/lcs_chk.sv ====
`timescale 1ns/100ps

module lcs_chk (
    input logic       i_clk,
    input logic       i_rst_b,
    input logic       i_iface_select_reset,
    input logic       i_scl_in,
    input logic       i_sda_in,
    input logic       i_hot_plug,
    input logic       i_rx_sense,
    input logic       i_edge_strap,
    input logic       i_power_down_n,
    input logic       o_scl_out,
    input logic       o_scl_oe,
    input logic       o_sda_out,
    input logic       o_sda_oe,
    input logic       o_monitor_sense_out,
    input logic       o_monitor_sense_oe,
    input logic       o_edge_rising,
    input logic       o_power_down_n,
    input logic [2:0] o_link_data_en,
    input logic       o_link_clock_en
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    wire sel = i_iface_select_reset;

    a_scl_never_drv: assert property (!o_scl_oe && !o_scl_out)
        else $error("Bus clock line driven");
    a_sda_low_only: assert property (!o_sda_out)
        else $error("Bus data line driven high");
    a_desel_no_ack: assert property (sel[*6] |-> !o_sda_oe)
        else $error("Data line pulled while port deselected");
    a_mon_low_only: assert property (!o_monitor_sense_out)
        else $error("Monitor sense driven high");
    // Six quiet cycles cover the synchroniser plus output flop latency
    a_sense_follow: assert property ((sel && $stable(sel) && $stable(i_rx_sense))[*6]
        |-> o_monitor_sense_oe == !i_rx_sense)
        else $error("Monitor sense does not follow receiver sense");
    // Judged from the strap pin so that a broken enable path cannot hide
    a_pwr_tristate: assert property ((sel && !i_power_down_n)[*5]
        |-> !o_power_down_n && o_link_data_en == 3'h0 && !o_link_clock_en)
        else $error("Link drivers enabled in power down");
    a_strap_edge: assert property ((sel && $stable(sel) && $stable(i_edge_strap))[*5]
        |-> o_edge_rising == i_edge_strap)
        else $error("Edge output not taken from strap");
    a_strap_pwr: assert property ((sel && $stable(sel) && $stable(i_power_down_n))[*5]
        |-> o_power_down_n == i_power_down_n)
        else $error("Power output not taken from strap");
    a_strap_ignored: assert property ((!sel)[*8] ##0 $changed(i_edge_strap)
        |=> $stable(o_edge_rising)[*4])
        else $error("Edge strap leaks through while port enabled");

    c_ack: cover property (o_sda_oe);
    c_event: cover property (!sel && o_monitor_sense_oe);
    c_sel_fall: cover property ($fell(sel));
endmodule

bind lcs_top lcs_chk lcs_chk_i (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_iface_select_reset(i_iface_select_reset),
    .i_scl_in(i_scl_in), .i_sda_in(i_sda_in), .i_hot_plug(i_hot_plug),
    .i_rx_sense(i_rx_sense), .i_edge_strap(i_edge_strap), .i_power_down_n(i_power_down_n),
    .o_scl_out(o_scl_out), .o_scl_oe(o_scl_oe), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
    .o_monitor_sense_out(o_monitor_sense_out), .o_monitor_sense_oe(o_monitor_sense_oe),
    .o_edge_rising(o_edge_rising), .o_power_down_n(o_power_down_n),
    .o_link_data_en(o_link_data_en), .o_link_clock_en(o_link_clock_en)
);

// ==== verif/lcs_host.sv ====
`timescale 1ns/100ps

// Bus host: a one only releases a line, so the pull-up gives the high level
module lcs_host (
    input  logic i_clk,
    input  logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    // Eight cycles per half keeps each clock level above the five-cycle minimum
    task automatic half();
        repeat (8) @(negedge i_clk);
    endtask

    // Data moves a half period after the clock fall, never while clock is high
    task automatic clk_bit(input logic b, output logic r);
        o_sda = b;
        half();
        o_scl = 1'b1;
        half();
        r = i_sda;
        o_scl = 1'b0;
        half();
    endtask

    // Also serves as a repeated start
    task automatic start();
        o_sda = 1'b1;
        half();
        o_scl = 1'b1;
        half();
        o_sda = 1'b0;
        half();
        o_scl = 1'b0;
        half();
    endtask

    task automatic stop();
        o_sda = 1'b0;
        half();
        o_scl = 1'b1;
        half();
        o_sda = 1'b1;
        half();
    endtask

    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            clk_bit(tx[i], rx[i]);
        end
        clk_bit(1'b1, ack);
    endtask

    task automatic wr(input logic [6:0] adr, input logic [7:0] sub, input logic [7:0] dat,
                      output logic ok);
        logic [7:0] rx;
        logic       a0;
        logic       a1;
        logic       a2;
        start();
        xfer({adr, 1'b0}, rx, a0);
        xfer(sub, rx, a1);
        xfer(dat, rx, a2);
        stop();
        ok = !(a0 | a1 | a2);
    endtask

    // Single byte read, closed with a not-acknowledge since bursts are not offered
    task automatic rd(input logic [6:0] adr, input logic [7:0] sub, output logic [7:0] dat,
                      output logic ok);
        logic [7:0] rx;
        logic       a0;
        logic       a1;
        logic       a2;
        logic       a3;
        start();
        xfer({adr, 1'b0}, rx, a0);
        xfer(sub, rx, a1);
        start();
        xfer({adr, 1'b1}, rx, a2);
        xfer(8'hff, dat, a3);
        stop();
        ok = !(a0 | a1 | a2);
    endtask
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/100ps
`include "lcs_defs.vh"

module testbench;
    localparam logic [6:0] adr = `LCS_SLAVE_ADDR;
    logic       i_clk;
    logic       i_rst_b;
    logic       sel;
    logic       hp;
    logic       rsen;
    logic       strap_edge;
    logic       strap_pdn;
    wire        h_scl;
    wire        h_sda;
    wire        scl_out;
    wire        scl_oe;
    wire        sda_out;
    wire        sda_oe;
    wire        ms_out;
    wire        ms_oe;
    wire        edge_rise;
    wire        pwr_n;
    wire  [2:0] data_en;
    wire        clk_en;
    int         err_total;
    int         tests_run;
    int         cycles;

    // Open-drain lines resolved against their pull-ups
    wire       scl_w = h_scl & (~scl_oe | scl_out);
    wire       sda_w = h_sda & (~sda_oe | sda_out);
    wire       ms_w  = ~ms_oe | ms_out;
    wire [7:0] obs   = {2'h0, clk_en, data_en, pwr_n, edge_rise};

    lcs_top lcs_top_i (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_iface_select_reset(sel), .i_scl_in(scl_w),
        .i_sda_in(sda_w), .i_hot_plug(hp), .i_rx_sense(rsen), .i_edge_strap(strap_edge),
        .i_power_down_n(strap_pdn), .o_scl_out(scl_out), .o_scl_oe(scl_oe),
        .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_monitor_sense_out(ms_out),
        .o_monitor_sense_oe(ms_oe), .o_edge_rising(edge_rise), .o_power_down_n(pwr_n),
        .o_link_data_en(data_en), .o_link_clock_en(clk_en)
    );

    lcs_host lcs_host_i (.i_clk(i_clk), .i_sda(sda_w), .o_scl(h_scl), .o_sda(h_sda));

    always #2.5 i_clk = ~i_clk;

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    task automatic t_strap();
        sel = 1'b1;
        for (int k = 0; k < 4; k++) begin
            strap_edge = k[0];
            strap_pdn = k[1];
            idle(8);
            chk(obs, {2'h0, {5{k[1]}}, k[0]});
        end
    endtask

    // Hot plug is set opposite to receiver sense to show it is not used here
    task automatic t_sense_off();
        for (int k = 0; k < 2; k++) begin
            rsen = k[0];
            hp = ~k[0];
            idle(8);
            chk(ms_w, k[0]);
        end
    endtask

    task automatic t_port();
        logic       ok;
        logic [7:0] d;
        strap_edge = 1'b1;
        strap_pdn = 1'b1;
        idle(24);
        sel = 1'b0;
        idle(10);
        chk(obs, 8'h00);
        lcs_host_i.wr(adr, 8'h08, 8'h37, ok);
        chk(ok, 1'b1);
        idle(4);
        chk(obs, 8'h3f);
        strap_edge = 1'b0;
        idle(8);
        chk(obs, 8'h3f);
        lcs_host_i.rd(adr, 8'h08, d, ok);
        chk(ok, 1'b1);
        chk(d, 8'h37);
        lcs_host_i.wr(7'h71, 8'h08, 8'h34, ok);
        chk(ok, 1'b0);
        chk(obs, 8'h3f);
        hp = 1'b1;
        rsen = 1'b0;
        idle(8);
        lcs_host_i.rd(adr, 8'h09, d, ok);
        chk(d, 8'h01);
    endtask

    task automatic t_monitor_sense_out();
        logic       ok;
        logic [7:0] d;
        for (int m = 0; m < 2; m++) begin
            lcs_host_i.wr(adr, 8'h10, m[7:0], ok);
            for (int v = 0; v < 2; v++) begin
                hp = v[0] ^ m[0];
                rsen = ~(v[0] ^ m[0]);
                idle(8);
                chk(ms_w, v[0]);
            end
        end
        lcs_host_i.wr(adr, 8'h10, 8'h02, ok);
        lcs_host_i.wr(adr, 8'h11, 8'h03, ok);
        idle(8);
        chk(ms_w, 1'b1);
        hp = ~hp;
        idle(8);
        chk(ms_w, 1'b0);
        lcs_host_i.rd(adr, 8'h11, d, ok);
        chk(d, 8'h01);
        lcs_host_i.wr(adr, 8'h11, 8'h01, ok);
        idle(8);
        chk(ms_w, 1'b1);
    endtask

    task automatic t_sel_reset();
        logic       ok;
        logic [7:0] d;
        sel = 1'b1;
        idle(24);
        chk(obs, 8'h3e);
        lcs_host_i.wr(adr, 8'h08, 8'h37, ok);
        chk(ok, 1'b0);
        sel = 1'b0;
        idle(10);
        lcs_host_i.rd(adr, 8'h08, d, ok);
        chk(ok, 1'b1);
        chk(d, 8'h34);
        lcs_host_i.rd(adr, 8'h10, d, ok);
        chk(d, 8'h00);
    endtask

    // Ceiling is nearly three times the expected run length
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_total++;
            give_verdict();
        end
    end

    initial begin
        i_clk = 1'b0;
        i_rst_b = 1'b0;
        sel = 1'b1;
        hp = 1'b0;
        rsen = 1'b0;
        strap_edge = 1'b0;
        strap_pdn = 1'b0;
        err_total = 0;
        tests_run = 0;
        cycles = 0;
        idle(2);
        i_rst_b = 1'b1;
        t_strap();
        t_sense_off();
        t_port();
        t_monitor_sense_out();
        t_sel_reset();
        give_verdict();
    end
endmodule
